// ===== rtl/jrxlc_pkg.sv
// Package for the receive link control register bank
package jrxlc_pkg;
    localparam logic [11:0] ADDR_LANE_PLL_DIV = 12'h289;
    localparam logic [11:0] ADDR_TERM_CAL = 12'h2a7;
    localparam logic [11:0] ADDR_GEN_CTRL_A = 12'h300;
    localparam logic [11:0] ADDR_GEN_CTRL_B = 12'h301;
    localparam logic [11:0] ADDR_LATENCY0 = 12'h302;
    localparam logic [11:0] ADDR_MF_OFFSET0 = 12'h304;
    localparam logic [11:0] ADDR_READOUT0 = 12'h306;
    localparam logic [11:0] ADDR_SUM_A = 12'h40e;
    localparam logic [11:0] ADDR_SUM_B = 12'h41e;
    localparam logic [11:0] ADDR_SUM_C = 12'h426;
    localparam logic [11:0] ADDR_PACK_FIRST = 12'h450;
    localparam logic [11:0] ADDR_PACK_LAST = 12'h45c;
    localparam int PACK_COUNT = 13;
    localparam int CHECKSUM_MODE_BIT = 6;
    localparam int LINK_EN_BIT = 0;
    localparam logic [1:0] DIV_BY4 = 2'h0;
    localparam logic [1:0] DIV_BY2 = 2'h1;
    localparam logic [1:0] DIV_BY1 = 2'h2;
    localparam logic [2:0] SYNC_CLASS0 = 3'h0;
    localparam logic [2:0] SYNC_CLASS1 = 3'h1;
    localparam logic [7:0] RST_PLL_DIV = 8'hfc;
    localparam logic [7:0] RST_TERM_CAL = 8'h00;
    localparam logic [7:0] RST_CTRL_A = 8'h00;
    localparam logic [7:0] RST_CTRL_B = 8'h01;
    localparam logic [4:0] RST_MF_OFFSET = 5'h00;
    localparam logic [4:0] RST_READOUT = 5'h06;
    localparam logic [4:0] READOUT_MAX = 5'h0a;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [7:0] wdata;
    } jrxlc_req_s;
endpackage

// ===== rtl/jrxlc_top.sv
// Receive link control: registers, ref divider, cal trigger, checksum, multiframe delay
`timescale 1ns/100ps
// Functional notes
// - Divider code 01 halves the lane PLL reference clock.
// - Divider code 10 passes the reference clock undivided.
// - Code 00 divides by four; software keeps divided reference 35 to 80 MHz.
// - Only a rising edge of the termination cal bit starts calibration.
// - Local parameter checksum is placed in the computed-sum registers.
// - Checksum mode 0 sums individual link configuration fields.
// - Checksum mode 1 sums packed configuration bytes modulo 256.
// - Read-only latency field reports word cycles from rx multiframe to last boundary.
// - Rx multiframe clock is local multiframe clock delayed by programmed offset.
module jrxlc_top
    import jrxlc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port
    input wire jrxlc_req_s reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Reference clock
    input wire logic ref_clk_in,
    output logic ref_clk_div,
    // Packed link configuration bytes and individual field sum
    input wire logic [8*PACK_COUNT-1:0] packed_cfg,
    input wire logic [7:0] field_sum,
    // Multiframe timing (frame clock tick and word clock tick on core_clk)
    input wire logic frame_tick,
    input wire logic word_tick,
    input wire logic local_mf,
    input wire logic last_boundary,
    output logic rx_mf,
    // Link controls
    output logic term_cal_start,
    output logic link_enable,
    output logic sync_class1,
    output logic [4:0] readout_delay_buffer
);
    logic [7:0] div_q, div_d, term_q, term_d, ctla_q, ctla_d, ctlb_q, ctlb_d;
    logic [4:0] mfo_q, mfo_d, rob_q, rob_d, lat_q, lat_d, latcnt_q, latcnt_d;
    logic [7:0] rdata_q, rdata_d, sum_q, sum_d;
    logic rvalid_q, rvalid_d, cal_q, cal_d;
    logic [2:0] ref_sync_q;
    logic [1:0] refdiv_q, refdiv_d;
    logic refout_q, refout_d;
    logic [4:0] dly_q, dly_d;
    logic dly_run_q, dly_run_d, rxmf_q, rxmf_d, cnt_run_q, cnt_run_d;
    logic [7:0] pack_sum;
    logic unit_tick;
    logic ref_lvl_q, ref_lvl_d, ref_chg;
    logic cls1_q, cls1_d;

    function automatic logic [7:0] byte_sum(input logic [8*PACK_COUNT-1:0] b);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < PACK_COUNT; i++)
        begin
            s = s + b[8*i +: 8];
        end
        return s;
    endfunction

    // Register writes and readback
    always_comb
    begin
        div_d = div_q;
        term_d = term_q;
        ctla_d = ctla_q;
        ctlb_d = ctlb_q;
        mfo_d = mfo_q;
        rob_d = rob_q;
        rvalid_d = reg_req.rd;
        rdata_d = rdata_q;
        if (reg_req.wr)
        begin
            case (reg_req.addr)
                ADDR_LANE_PLL_DIV: div_d = reg_req.wdata;
                ADDR_TERM_CAL: term_d = {7'h00, reg_req.wdata[0]};
                ADDR_GEN_CTRL_A: ctla_d = {1'b0, reg_req.wdata[CHECKSUM_MODE_BIT], 5'h00, reg_req.wdata[LINK_EN_BIT]};
                ADDR_GEN_CTRL_B: ctlb_d = reg_req.wdata;
                ADDR_MF_OFFSET0: mfo_d = reg_req.wdata[4:0];
                // Clamp protects the buffer from an illegal depth
                ADDR_READOUT0: rob_d = (reg_req.wdata[4:0] > READOUT_MAX) ? READOUT_MAX : reg_req.wdata[4:0];
                default: ;
            endcase
        end
        if (reg_req.rd)
        begin
            case (reg_req.addr)
                ADDR_LANE_PLL_DIV: rdata_d = div_q;
                ADDR_TERM_CAL: rdata_d = term_q;
                ADDR_GEN_CTRL_A: rdata_d = ctla_q;
                ADDR_GEN_CTRL_B: rdata_d = ctlb_q;
                ADDR_LATENCY0: rdata_d = {3'h0, lat_q};
                ADDR_MF_OFFSET0: rdata_d = {3'h0, mfo_q};
                ADDR_READOUT0: rdata_d = {3'h0, rob_q};
                ADDR_SUM_A, ADDR_SUM_B, ADDR_SUM_C: rdata_d = sum_q;
                default: rdata_d = 8'h00;
            endcase
        end
        // Registered decode keeps the class output straight off a flop
        cls1_d = (ctlb_d[2:0] == SYNC_CLASS1);
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_q <= RST_PLL_DIV;
            term_q <= RST_TERM_CAL;
            ctla_q <= RST_CTRL_A;
            ctlb_q <= RST_CTRL_B;
            cls1_q <= (RST_CTRL_B[2:0] == SYNC_CLASS1);
            mfo_q <= RST_MF_OFFSET;
            rob_q <= RST_READOUT;
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end
        else
        begin
            div_q <= div_d;
            term_q <= term_d;
            ctla_q <= ctla_d;
            ctlb_q <= ctlb_d;
            cls1_q <= cls1_d;
            mfo_q <= mfo_d;
            rob_q <= rob_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // Checksum, cal edge, latency counter, reference divider, multiframe delay
    assign pack_sum = byte_sum(packed_cfg);
    // A reference change counts only once stages two and three agree, which filters glitches
    assign ref_chg = (ref_sync_q[1] == ref_sync_q[2]) && (ref_sync_q[2] != ref_lvl_q);
    assign unit_tick = (ctlb_q[2:0] == SYNC_CLASS1) ? frame_tick : word_tick;

    always_comb
    begin
        sum_d = ctla_q[CHECKSUM_MODE_BIT] ? pack_sum : field_sum;
        cal_d = term_d[0] & ~term_q[0];
        // Latency: word cycles from rx multiframe to the first boundary after it
        latcnt_d = latcnt_q;
        cnt_run_d = cnt_run_q;
        lat_d = lat_q;
        if (rxmf_q)
        begin
            latcnt_d = 5'h00;
            cnt_run_d = 1'b1;
        end
        else if (cnt_run_q && last_boundary)
        begin
            lat_d = latcnt_q;
            cnt_run_d = 1'b0;
        end
        else if (cnt_run_q && word_tick && latcnt_q != 5'h1f)
        begin
            latcnt_d = latcnt_q + 5'h01;
        end
        // Reference clock sampled on core_clk; divider counts rising edges of the sampled reference
        refdiv_d = refdiv_q;
        refout_d = refout_q;
        ref_lvl_d = ref_lvl_q;
        if (ref_chg)
        begin
            ref_lvl_d = ref_sync_q[2];
            case (div_q[1:0])
                DIV_BY2: refout_d = ref_sync_q[2] ? ~refout_q : refout_q;
                DIV_BY1: refout_d = ref_sync_q[2];
                default:
                begin
                    if (ref_sync_q[2])
                    begin
                        refdiv_d = refdiv_q + 2'h1;
                        if (refdiv_q[0])
                        begin
                            refout_d = ~refout_q;
                        end
                    end
                end
            endcase
        end
        // Delay line: rx multiframe follows local one after mfo units
        dly_d = dly_q;
        dly_run_d = dly_run_q;
        rxmf_d = 1'b0;
        if (local_mf)
        begin
            if (mfo_q == 5'h00)
            begin
                rxmf_d = 1'b1;
            end
            else
            begin
                dly_d = mfo_q;
                dly_run_d = 1'b1;
            end
        end
        else if (dly_run_q && unit_tick)
        begin
            dly_d = dly_q - 5'h01;
            if (dly_q == 5'h01)
            begin
                rxmf_d = 1'b1;
                dly_run_d = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sum_q <= 8'h00;
            cal_q <= 1'b0;
            lat_q <= 5'h00;
            latcnt_q <= 5'h00;
            cnt_run_q <= 1'b0;
            ref_sync_q <= 3'h0;
            ref_lvl_q <= 1'b0;
            refdiv_q <= 2'h0;
            refout_q <= 1'b0;
            dly_q <= 5'h00;
            dly_run_q <= 1'b0;
            rxmf_q <= 1'b0;
        end
        else
        begin
            sum_q <= sum_d;
            cal_q <= cal_d;
            lat_q <= lat_d;
            latcnt_q <= latcnt_d;
            cnt_run_q <= cnt_run_d;
            ref_sync_q <= {ref_sync_q[1:0], ref_clk_in};
            ref_lvl_q <= ref_lvl_d;
            refdiv_q <= refdiv_d;
            refout_q <= refout_d;
            dly_q <= dly_d;
            dly_run_q <= dly_run_d;
            rxmf_q <= rxmf_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign ref_clk_div = refout_q;
    assign term_cal_start = cal_q;
    assign link_enable = ctla_q[LINK_EN_BIT];
    assign sync_class1 = cls1_q;
    assign rx_mf = rxmf_q;
    assign readout_delay_buffer = rob_q;

    AST_CAL_EDGE: assert property (@(posedge core_clk) disable iff (!rst_n)
        term_cal_start |-> $past(term_q[0]) == 1'b0 && term_q[0])
        else $error("cal start without rising edge");
    AST_CAL_LEVEL: assert property (@(posedge core_clk) disable iff (!rst_n)
        term_q[0] && $past(term_q[0]) |-> !term_cal_start)
        else $error("cal start on steady level");
    AST_CAL_ONE: assert property (@(posedge core_clk) disable iff (!rst_n)
        term_cal_start |=> !term_cal_start)
        else $error("cal start longer than one cycle");
    AST_SUM_MODE1: assert property (@(posedge core_clk) disable iff (!rst_n)
        ctla_q[CHECKSUM_MODE_BIT] && $stable(packed_cfg) && $stable(ctla_q) |=> sum_q == $past(pack_sum))
        else $error("packed checksum wrong");
    AST_SUM_MODE0: assert property (@(posedge core_clk) disable iff (!rst_n)
        !ctla_q[CHECKSUM_MODE_BIT] |=> sum_q == $past(field_sum))
        else $error("field checksum wrong");
    AST_SUM_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
        reg_req.rd && reg_req.addr == ADDR_SUM_A |=> reg_rvalid && reg_rdata == $past(sum_q))
        else $error("checksum readback wrong");
    AST_MF_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
        local_mf && mfo_q == 5'h00 |=> rx_mf)
        else $error("zero offset multiframe late");
    AST_MF_IDLE: assert property (@(posedge core_clk) disable iff (!rst_n)
        !local_mf && !dly_run_q |=> !rx_mf)
        else $error("multiframe without local one");
    AST_LAT_RO: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(cnt_run_q && last_boundary) |=> $stable(lat_q))
        else $error("latency changed without boundary");
    AST_ROB_MAX: assert property (@(posedge core_clk) disable iff (!rst_n)
        readout_delay_buffer <= READOUT_MAX)
        else $error("readout delay above limit");
    AST_CLASS: assert property (@(posedge core_clk) disable iff (!rst_n)
        sync_class1 == (ctlb_q[2:0] == SYNC_CLASS1))
        else $error("sync class decode wrong");
    AST_DIV1: assert property (@(posedge core_clk) disable iff (!rst_n)
        div_q[1:0] == DIV_BY1 && $stable(div_q) && ref_chg |=> ref_clk_div == $past(ref_sync_q[2]))
        else $error("undivided ref wrong");
    AST_DIV2: assert property (@(posedge core_clk) disable iff (!rst_n)
        div_q[1:0] == DIV_BY2 && ref_chg && ref_sync_q[2] |=> ref_clk_div != $past(ref_clk_div))
        else $error("half ref did not toggle");
    AST_DIV4: assert property (@(posedge core_clk) disable iff (!rst_n)
        div_q[1:0] == DIV_BY4 && ref_chg && ref_sync_q[2] && !refdiv_q[0] |=> $stable(ref_clk_div))
        else $error("quarter ref toggled early");
    COV_CAL: cover property (@(posedge core_clk) disable iff (!rst_n) term_cal_start);
    COV_MF: cover property (@(posedge core_clk) disable iff (!rst_n) local_mf && mfo_q != 5'h00 ##[1:200] rx_mf);
    COV_LAT: cover property (@(posedge core_clk) disable iff (!rst_n) cnt_run_q && last_boundary);
    COV_MODE1: cover property (@(posedge core_clk) disable iff (!rst_n) ctla_q[CHECKSUM_MODE_BIT]);
    COV_CLASS0: cover property (@(posedge core_clk) disable iff (!rst_n) !sync_class1 && local_mf && mfo_q != 5'h00);
endmodule // jrxlc_top

// ===== bench/jrxlc_far_model.sv
// Far-side model: slow reference clock plus frame and word clock ticks
`timescale 1ns/100ps
module jrxlc_far_model
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Timing toward the block
    output logic ref_clk_in,
    output logic frame_tick,
    output logic word_tick
);
    int cnt;
    // Reference kept far below core_clk/2 so the sampler never misses an edge
    initial
    begin
        cnt = 0;
        ref_clk_in = 1'b0;
        frame_tick = 1'b0;
        word_tick = 1'b0;
        forever
        begin
            @(posedge core_clk);
            cnt = rst_n ? cnt + 1 : 0;
            // Non-blocking updates keep the bench's sampling after the edge free of races
            ref_clk_in <= cnt[3];
            // Unequal periods, so a wrong unit choice shows up in the delay
            frame_tick <= (cnt % 3 == 0);
            word_tick <= (cnt % 4 == 2);
        end
    end
endmodule // jrxlc_far_model

// ===== bench/tb_top.sv
// Self-checking testbench for the receive link control block
`timescale 1ns/100ps
module tb_top
    import jrxlc_pkg::*;
;
    logic core_clk, rst_n, reg_rvalid, ref_clk_in, ref_clk_div, frame_tick, word_tick;
    logic local_mf, last_boundary, rx_mf, term_cal_start, link_enable, sync_class1;
    jrxlc_req_s req;
    logic [8*PACK_COUNT-1:0] packed_cfg;
    logic [7:0] reg_rdata, field_sum, cfg_sum;
    logic [4:0] readout_delay_buffer;
    int err_count = 0;
    int n_tests = 0;

    jrxlc_top dut
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .reg_req(req),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .ref_clk_in(ref_clk_in),
        .ref_clk_div(ref_clk_div),
        .packed_cfg(packed_cfg),
        .field_sum(field_sum),
        .frame_tick(frame_tick),
        .word_tick(word_tick),
        .local_mf(local_mf),
        .last_boundary(last_boundary),
        .rx_mf(rx_mf),
        .term_cal_start(term_cal_start),
        .link_enable(link_enable),
        .sync_class1(sync_class1),
        .readout_delay_buffer(readout_delay_buffer)
    );

    jrxlc_far_model far
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ref_clk_in(ref_clk_in),
        .frame_tick(frame_tick),
        .word_tick(word_tick)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task step;
        @(posedge core_clk);
        #1;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask

    // An idle edge before each request keeps strobes from being re-driven in one step
    task wr(input logic [11:0] a, input logic [7:0] d);
        step;
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        step;
        req.wr = 1'b0;
    endtask

    task rd_chk(input logic [11:0] a, input logic [7:0] exp);
        step;
        req.rd = 1'b1;
        req.addr = a;
        step;
        req.rd = 1'b0;
        chk({7'h0, reg_rvalid}, 8'h01);
        chk(reg_rdata, exp);
    endtask

    task conclude;
        if (err_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task test_reset;
        chk({7'h0, sync_class1}, 8'h01);
        chk({3'h0, readout_delay_buffer}, 8'h06);
        rd_chk(ADDR_GEN_CTRL_B, 8'h01);
        rd_chk(ADDR_GEN_CTRL_A, 8'h00);
        rd_chk(ADDR_TERM_CAL, 8'h00);
        rd_chk(ADDR_MF_OFFSET0, 8'h00);
        rd_chk(ADDR_LATENCY0, 8'h00);
        rd_chk(ADDR_READOUT0, 8'h06);
        rd_chk(ADDR_LANE_PLL_DIV, 8'hfc);
        rd_chk(12'h7f0, 8'h00);
    endtask

    task test_cal;
        wr(ADDR_TERM_CAL, 8'hff);
        chk({7'h0, term_cal_start}, 8'h01);
        step;
        chk({7'h0, term_cal_start}, 8'h00);
        rd_chk(ADDR_TERM_CAL, 8'h01);
        wr(ADDR_TERM_CAL, 8'h01);
        chk({7'h0, term_cal_start}, 8'h00);
        wr(ADDR_TERM_CAL, 8'h00);
        chk({7'h0, term_cal_start}, 8'h00);
    endtask

    // Parameters are in place before the link is enabled
    task test_sum;
        cfg_sum = 8'h00;
        for (int i = 0; i < PACK_COUNT; i++)
        begin
            packed_cfg[8*i+:8] = 8'(8'h07 + 8'h1d * i);
            cfg_sum = cfg_sum + packed_cfg[8*i+:8];
        end
        field_sum = 8'ha5;
        rd_chk(ADDR_SUM_A, 8'ha5);
        wr(ADDR_GEN_CTRL_A, 8'hff);
        chk({7'h0, link_enable}, 8'h01);
        rd_chk(ADDR_GEN_CTRL_A, 8'h41);
        rd_chk(ADDR_SUM_A, cfg_sum);
        rd_chk(ADDR_SUM_B, cfg_sum);
        rd_chk(ADDR_SUM_C, cfg_sum);
        wr(ADDR_GEN_CTRL_A, 8'h01);
        rd_chk(ADDR_SUM_C, 8'ha5);
        wr(ADDR_READOUT0, 8'h0b);
        chk({3'h0, readout_delay_buffer}, 8'h0a);
        wr(ADDR_READOUT0, 8'h09);
        chk({3'h0, readout_delay_buffer}, 8'h09);
        rd_chk(ADDR_READOUT0, 8'h09);
    endtask

    // Window of 40 reference periods; one edge of slack for the sampler phase
    task div_chk(input logic [1:0] code, input int exp);
        int k;
        logic p;
        wr(ADDR_LANE_PLL_DIV, {6'h3f, code});
        repeat (100) step;
        k = 0;
        p = ref_clk_div;
        repeat (640)
        begin
            step;
            if (ref_clk_div && !p)
                k++;
            p = ref_clk_div;
        end
        if (k == exp - 1 || k == exp + 1)
            k = exp;
        chk(k[7:0], exp[7:0]);
    endtask

    task mf_chk(input logic [2:0] cls, input int n);
        int k;
        logic t;
        wr(ADDR_GEN_CTRL_B, {5'h0, cls});
        chk({7'h0, sync_class1}, {7'h0, cls == SYNC_CLASS1});
        wr(ADDR_MF_OFFSET0, n[7:0]);
        local_mf = 1'b1;
        step;
        local_mf = 1'b0;
        k = 0;
        while (k < n)
        begin
            chk({7'h0, rx_mf}, 8'h00);
            t = (cls == SYNC_CLASS1) ? frame_tick : word_tick;
            step;
            if (t)
                k++;
        end
        chk({7'h0, rx_mf}, 8'h01);
        if (cls == SYNC_CLASS0)
        begin
            k = 0;
            repeat (9)
            begin
                t = word_tick;
                step;
                if (t)
                    k++;
            end
            // Boundary lands off a word tick so the count is unambiguous
            while (word_tick)
            begin
                step;
                k++;
            end
            last_boundary = 1'b1;
            step;
            last_boundary = 1'b0;
            wr(ADDR_LATENCY0, 8'h1f);
            rd_chk(ADDR_LATENCY0, k[7:0]);
        end
    endtask

    initial
    begin
        req = '0;
        packed_cfg = '0;
        field_sum = 8'h00;
        local_mf = 1'b0;
        last_boundary = 1'b0;
        rst_n = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        test_reset;
        test_cal;
        test_sum;
        div_chk(DIV_BY4, 10);
        div_chk(DIV_BY2, 20);
        div_chk(DIV_BY1, 40);
        mf_chk(SYNC_CLASS0, 3);
        mf_chk(SYNC_CLASS1, 3);
        mf_chk(SYNC_CLASS1, 0);
        conclude;
    end

    initial
    begin
        #400000;
        err_count++;
        conclude;
    end
endmodule // tb_top
